/* File: rtl/ea_decode_pkg.sv */
package ea_decode_pkg;
  // Field widths
  localparam int CODE_W = 5;
  localparam int CYC_W = 8;
  // Code range bounds
  localparam logic [4:0] CODE_REG_LAST = 5'h07;
  localparam logic [4:0] CODE_IND_FIRST = 5'h08;
  localparam logic [4:0] CODE_IND_LAST = 5'h0b;
  localparam logic [4:0] CODE_INC_FIRST = 5'h0c;
  localparam logic [4:0] CODE_INC_LAST = 5'h0f;
  localparam logic [4:0] CODE_D8_FIRST = 5'h10;
  localparam logic [4:0] CODE_D8_LAST = 5'h17;
  localparam logic [4:0] CODE_D16_FIRST = 5'h18;
  localparam logic [4:0] CODE_D16_LAST = 5'h1b;
  localparam logic [4:0] CODE_IDX0 = 5'h1c;
  localparam logic [4:0] CODE_IDX1 = 5'h1d;
  localparam logic [4:0] CODE_PCREL = 5'h1e;
  localparam logic [4:0] CODE_ABS = 5'h1f;
  // Index register for the indexed forms
  localparam logic [2:0] INDEX_REG = 3'h7;
  // Extension byte counts
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_SHORT = 2'h1;
  localparam logic [1:0] EXT_WIDE = 2'h2;
  // Addressing-form cycles
  localparam logic [2:0] FORM_CYC_IND = 3'h1;
  localparam logic [2:0] FORM_CYC_INC = 3'h4;
  localparam logic [2:0] FORM_CYC_D8 = 3'h1;
  localparam logic [2:0] FORM_CYC_D16 = 3'h1;
  localparam logic [2:0] FORM_CYC_IDX = 3'h2;
  localparam logic [2:0] FORM_CYC_PCREL = 3'h2;
  localparam logic [2:0] FORM_CYC_ABS = 3'h1;
  // Pointer increments
  localparam logic [2:0] INC_BYTE = 3'h1;
  localparam logic [2:0] INC_WORD = 3'h2;
  localparam logic [2:0] INC_LONG = 3'h4;
  // Location corrections: byte, word, long
  localparam logic [2:0] CORR_ODD_RAM_W = 3'h1;
  localparam logic [2:0] CORR_ODD_RAM_L = 3'h2;
  localparam logic [2:0] CORR_EVEN_EXT_B = 3'h1;
  localparam logic [2:0] CORR_EVEN_EXT_W = 3'h1;
  localparam logic [2:0] CORR_EVEN_EXT_L = 3'h2;
  localparam logic [2:0] CORR_SLOW_B = 3'h1;
  localparam logic [2:0] CORR_SLOW_W = 3'h3;
  localparam logic [2:0] CORR_SLOW_L = 3'h6;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2
  } size_t;

  typedef enum logic [2:0] {
    LOC_REG = 3'h0,
    LOC_RAM_EVEN = 3'h1,
    LOC_RAM_ODD = 3'h2,
    LOC_EXT_EVEN = 3'h3,
    LOC_EXT_ODD = 3'h4,
    LOC_BUS8 = 3'h5
  } loc_t;

  typedef enum logic [7:0] {
    MODE_REG_DIRECT = 8'h01,
    MODE_INDIRECT = 8'h02,
    MODE_POST_INC = 8'h04,
    MODE_SHORT_OFS = 8'h08,
    MODE_WIDE_OFS = 8'h10,
    MODE_INDEXED = 8'h20,
    MODE_PC_REL = 8'h40,
    MODE_ABSOLUTE = 8'h80
  } mode_t;
endpackage : ea_decode_pkg

/* File: rtl/access_correction.sv */
`timescale 1ns/1ps
module access_correction (
  // Access
  input wire ea_decode_pkg::size_t size,
  input wire ea_decode_pkg::loc_t loc,
  // Result
  output logic [2:0] corr
);
  import ea_decode_pkg::*;

  always_comb begin
    corr = 3'h0;
    unique case (loc)
      LOC_REG, LOC_RAM_EVEN: corr = 3'h0;
      LOC_RAM_ODD: begin
        if (size == SIZE_WORD) corr = CORR_ODD_RAM_W;
        else if (size == SIZE_LONG) corr = CORR_ODD_RAM_L;
      end
      LOC_EXT_EVEN: begin
        if (size == SIZE_BYTE) corr = CORR_EVEN_EXT_B;
        else if (size == SIZE_WORD) corr = CORR_EVEN_EXT_W;
        else corr = CORR_EVEN_EXT_L;
      end
      LOC_EXT_ODD, LOC_BUS8: begin
        if (size == SIZE_BYTE) corr = CORR_SLOW_B;
        else if (size == SIZE_WORD) corr = CORR_SLOW_W;
        else corr = CORR_SLOW_L;
      end
      default: corr = 3'h0;
    endcase
  end
endmodule : access_correction

/* File: rtl/effective_address_decode.sv */
`timescale 1ns/1ps
module effective_address_decode (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Decode request
  input wire logic DEC_VALID,
  input wire logic [4:0] OPERAND_LOCATOR_FIELD,
  input wire ea_decode_pkg::size_t OPERAND_SIZE,
  input wire logic [3:0] BASE_LENGTH,
  input wire logic LENGTH_EXTENDABLE,
  input wire logic [5:0] BASE_CYCLES,
  input wire logic MEM_ACCESS,
  input wire ea_decode_pkg::loc_t OPERAND_LOC,
  // Decode result
  output logic RESULT_VALID,
  output ea_decode_pkg::mode_t MODE,
  output logic IS_MEMORY,
  output logic [2:0] BYTE_REGISTER,
  output logic [2:0] WORD_REGISTER,
  output logic [1:0] LONG_REGISTER,
  output logic [1:0] LOW_WORD_POINTER,
  output logic [2:0] INDEX_REGISTER,
  output logic USES_INDEX,
  output logic USES_PC,
  output logic [1:0] EXT_BYTES,
  output logic SHORT_OFFSET_FIELD,
  output logic WIDE_OFFSET_FIELD,
  output logic ABSOLUTE_16BIT_LOCATION,
  output logic [2:0] POST_INC_STEP,
  output logic [2:0] FORM_CYCLES,
  output logic [2:0] LOC_CORRECTION,
  output logic [4:0] TOTAL_LENGTH,
  output logic [7:0] TOTAL_CYCLES
);
  import ea_decode_pkg::*;

  // ----------------------------------------
  // Combinational decode
  // ----------------------------------------
  mode_t mode_d;
  logic [1:0] ext_d;
  logic [2:0] form_d;
  logic [2:0] inc_d;
  logic [2:0] corr;
  logic [2:0] corr_d;
  logic [4:0] code;

  assign code = OPERAND_LOCATOR_FIELD;

  always_comb begin
    mode_d = MODE_REG_DIRECT;
    ext_d = EXT_NONE;
    form_d = 3'h0;
    if (code <= CODE_REG_LAST) begin
      mode_d = MODE_REG_DIRECT;
    end else if (code <= CODE_IND_LAST) begin
      mode_d = MODE_INDIRECT;
      form_d = FORM_CYC_IND;
    end else if (code <= CODE_INC_LAST) begin
      mode_d = MODE_POST_INC;
      form_d = FORM_CYC_INC;
    end else if (code <= CODE_D8_LAST) begin
      mode_d = MODE_SHORT_OFS;
      ext_d = EXT_SHORT;
      form_d = FORM_CYC_D8;
    end else if (code <= CODE_D16_LAST) begin
      mode_d = MODE_WIDE_OFS;
      ext_d = EXT_WIDE;
      form_d = FORM_CYC_D16;
    end else if (code == CODE_IDX0 || code == CODE_IDX1) begin
      mode_d = MODE_INDEXED;
      form_d = FORM_CYC_IDX;
    end else if (code == CODE_PCREL) begin
      mode_d = MODE_PC_REL;
      ext_d = EXT_WIDE;
      form_d = FORM_CYC_PCREL;
    end else begin
      mode_d = MODE_ABSOLUTE;
      ext_d = EXT_WIDE;
      form_d = FORM_CYC_ABS;
    end
  end

  always_comb begin
    inc_d = 3'h0;
    if (mode_d == MODE_POST_INC) begin
      unique case (OPERAND_SIZE)
        SIZE_BYTE: inc_d = INC_BYTE;
        SIZE_WORD: inc_d = INC_WORD;
        SIZE_LONG: inc_d = INC_LONG;
        default: inc_d = 3'h0;
      endcase
    end
  end

  access_correction u_corr (
    .size(OPERAND_SIZE),
    .loc(OPERAND_LOC),
    .corr(corr)
  );

  // Register operands never need a correction
  assign corr_d = (MEM_ACCESS && code > CODE_REG_LAST) ? corr : 3'h0;

  // ----------------------------------------
  // Result registers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      RESULT_VALID <= 1'b0;
    end else begin
      RESULT_VALID <= DEC_VALID;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      MODE <= MODE_REG_DIRECT;
      IS_MEMORY <= 1'b0;
      EXT_BYTES <= EXT_NONE;
      SHORT_OFFSET_FIELD <= 1'b0;
      WIDE_OFFSET_FIELD <= 1'b0;
      ABSOLUTE_16BIT_LOCATION <= 1'b0;
      USES_INDEX <= 1'b0;
      USES_PC <= 1'b0;
    end else if (DEC_VALID) begin
      MODE <= mode_d;
      IS_MEMORY <= (code >= CODE_IND_FIRST);
      EXT_BYTES <= ext_d;
      SHORT_OFFSET_FIELD <= (mode_d == MODE_SHORT_OFS);
      WIDE_OFFSET_FIELD <= (mode_d == MODE_WIDE_OFS) || (mode_d == MODE_PC_REL);
      ABSOLUTE_16BIT_LOCATION <= (mode_d == MODE_ABSOLUTE);
      USES_INDEX <= (mode_d == MODE_INDEXED);
      USES_PC <= (mode_d == MODE_PC_REL);
    end
  end

  // Register selection per operand size
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      BYTE_REGISTER <= 3'h0;
      WORD_REGISTER <= 3'h0;
      LONG_REGISTER <= 2'h0;
      LOW_WORD_POINTER <= 2'h0;
      INDEX_REGISTER <= 3'h0;
    end else if (DEC_VALID) begin
      BYTE_REGISTER <= code[2:0];
      WORD_REGISTER <= code[2:0];
      LONG_REGISTER <= code[2:1];
      if (mode_d == MODE_INDEXED) begin
        LOW_WORD_POINTER <= {1'b0, code[0]};
      end else begin
        LOW_WORD_POINTER <= code[1:0];
      end
      INDEX_REGISTER <= (mode_d == MODE_INDEXED) ? INDEX_REG : 3'h0;
    end
  end

  // Length and cycle totals
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      POST_INC_STEP <= 3'h0;
      FORM_CYCLES <= 3'h0;
      LOC_CORRECTION <= 3'h0;
      TOTAL_LENGTH <= 5'h00;
      TOTAL_CYCLES <= 8'h00;
    end else if (DEC_VALID) begin
      POST_INC_STEP <= inc_d;
      FORM_CYCLES <= form_d;
      LOC_CORRECTION <= corr_d;
      if (LENGTH_EXTENDABLE) begin
        TOTAL_LENGTH <= {1'b0, BASE_LENGTH} + {3'h0, ext_d};
      end else begin
        TOTAL_LENGTH <= {1'b0, BASE_LENGTH};
      end
      TOTAL_CYCLES <= {2'h0, BASE_CYCLES} + {5'h00, form_d} + {5'h00, corr_d};
    end
  end
endmodule : effective_address_decode

/* File: test/ea_props.sv */
`timescale 1ns/1ps
module ea_props (
  // Watched ports
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic DEC_VALID,
  input wire logic [4:0] OPERAND_LOCATOR_FIELD,
  input wire ea_decode_pkg::size_t OPERAND_SIZE,
  input wire logic [3:0] BASE_LENGTH,
  input wire logic LENGTH_EXTENDABLE,
  input wire logic [5:0] BASE_CYCLES,
  input wire logic RESULT_VALID,
  input wire ea_decode_pkg::mode_t MODE,
  input wire logic IS_MEMORY,
  input wire logic [1:0] LOW_WORD_POINTER,
  input wire logic [2:0] INDEX_REGISTER,
  input wire logic [1:0] EXT_BYTES,
  input wire logic [2:0] POST_INC_STEP,
  input wire logic [2:0] FORM_CYCLES,
  input wire logic [2:0] LOC_CORRECTION,
  input wire logic [4:0] TOTAL_LENGTH,
  input wire logic [7:0] TOTAL_CYCLES
);
  import ea_decode_pkg::*;
  wire logic [4:0] c = OPERAND_LOCATOR_FIELD;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  answer_latency_a: assert property (RESULT_VALID == $past(DEC_VALID))
    else $error("result valid not one cycle after request");
  reg_class_a: assert property (DEC_VALID && c < 5'h08 |=> MODE == MODE_REG_DIRECT &&
    !IS_MEMORY && EXT_BYTES == 2'h0 && LOC_CORRECTION == 3'h0) else $error("register code");
  post_inc_a: assert property (DEC_VALID && c[4:2] == 3'b011 |=> FORM_CYCLES == 3'h4 &&
    POST_INC_STEP == 3'(3'h1 << $past(OPERAND_SIZE))) else $error("post increment wrong");
  short_ofs_a: assert property (DEC_VALID && c[4:3] == 2'b10 |=> EXT_BYTES == 2'h1 &&
    FORM_CYCLES == 3'h1) else $error("short offset form wrong");
  wide_ext_a: assert property (DEC_VALID && (c[4:2] == 3'b110 || c[4:1] == 4'hf)
    |=> EXT_BYTES == 2'h2) else $error("two extension bytes expected");
  index_form_a: assert property (DEC_VALID && c[4:1] == 4'he |=> INDEX_REGISTER == 3'h7 &&
    FORM_CYCLES == 3'h2 && LOW_WORD_POINTER == {1'b0, $past(c[0])}) else $error("indexed");
  length_sum_a: assert property (DEC_VALID |=> TOTAL_LENGTH ==
    5'($past(BASE_LENGTH)) + ($past(LENGTH_EXTENDABLE) ? 5'(EXT_BYTES) : 5'h0))
    else $error("total length wrong");
  cycle_sum_a: assert property (DEC_VALID |=> TOTAL_CYCLES ==
    8'($past(BASE_CYCLES)) + 8'(FORM_CYCLES) + 8'(LOC_CORRECTION)) else $error("cycles sum");
  result_hold_a: assert property (!DEC_VALID |=> $stable(TOTAL_CYCLES) && $stable(MODE))
    else $error("result changed without request");
endmodule : ea_props
bind effective_address_decode ea_props chk (.*);

/* File: test/seq_model.sv */
`timescale 1ns/1ps
module seq_model (
  // Request side
  input wire logic clk,
  output logic valid,
  output logic [4:0] code,
  output ea_decode_pkg::size_t size,
  output ea_decode_pkg::loc_t loc,
  output logic mem,
  output logic ext_ok
);
  import ea_decode_pkg::*;
  initial begin
    valid = 1'b0;
    code = 5'h00;
    size = SIZE_BYTE;
    loc = LOC_REG;
    mem = 1'b0;
    ext_ok = 1'b0;
  end
  // One-cycle request; code, mem and ext_ok scrambled once it is taken, size and loc held
  task automatic issue(input logic [4:0] c, input size_t s, input loc_t l, input logic m,
                       input logic e);
    @(posedge clk);
    #1;
    valid = 1'b1;
    code = c;
    size = s;
    loc = l;
    mem = m;
    ext_ok = e;
    @(posedge clk);
    #1;
    valid = 1'b0;
    code = ~c;
    mem = ~m;
    ext_ok = ~e;
  endtask : issue
endmodule : seq_model

/* File: test/effective_address_decode_tb.sv */
`timescale 1ns/1ps
module effective_address_decode_tb;
  import ea_decode_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic DEC_VALID, IS_MEMORY, RESULT_VALID, LENGTH_EXTENDABLE, MEM_ACCESS;
  logic [4:0] OPERAND_LOCATOR_FIELD, TOTAL_LENGTH;
  logic [2:0] WORD_REGISTER, INDEX_REGISTER, POST_INC_STEP, FORM_CYCLES, LOC_CORRECTION;
  logic [1:0] LOW_WORD_POINTER, EXT_BYTES;
  logic [7:0] TOTAL_CYCLES;
  logic [2:0] BYTE_REGISTER;
  logic [1:0] LONG_REGISTER;
  logic USES_INDEX, USES_PC, SHORT_OFFSET_FIELD, WIDE_OFFSET_FIELD, ABSOLUTE_16BIT_LOCATION;
  size_t OPERAND_SIZE;
  loc_t OPERAND_LOC;
  mode_t MODE;
  int n_fail = 0;
  int total_checks = 0;
  localparam logic [2:0] CTAB [6][3] = '{'{3'h0, 3'h0, 3'h0}, '{3'h0, 3'h0, 3'h0},
    '{3'h0, 3'h1, 3'h2}, '{3'h1, 3'h1, 3'h2}, '{3'h1, 3'h3, 3'h6}, '{3'h1, 3'h3, 3'h6}};
  always #2 CORE_CLK = ~CORE_CLK;
  seq_model seq (.clk(CORE_CLK), .valid(DEC_VALID), .code(OPERAND_LOCATOR_FIELD),
    .size(OPERAND_SIZE), .loc(OPERAND_LOC), .mem(MEM_ACCESS), .ext_ok(LENGTH_EXTENDABLE));
  effective_address_decode DUT (.CORE_CLK, .RST_N, .DEC_VALID, .OPERAND_LOCATOR_FIELD,
    .OPERAND_SIZE, .BASE_LENGTH(4'hf), .LENGTH_EXTENDABLE, .BASE_CYCLES(6'h3f), .MEM_ACCESS,
    .OPERAND_LOC, .RESULT_VALID, .MODE, .IS_MEMORY, .BYTE_REGISTER, .WORD_REGISTER,
    .LONG_REGISTER, .LOW_WORD_POINTER, .INDEX_REGISTER, .USES_INDEX, .USES_PC,
    .EXT_BYTES, .SHORT_OFFSET_FIELD, .WIDE_OFFSET_FIELD, .ABSOLUTE_16BIT_LOCATION,
    .POST_INC_STEP, .FORM_CYCLES, .LOC_CORRECTION, .TOTAL_LENGTH, .TOTAL_CYCLES);
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Mode, extension bytes, form cycles
  function automatic logic [12:0] exp_of(input logic [4:0] c);
    if (c < 5'h08) return {8'h01, 2'h0, 3'h0};
    if (c < 5'h0c) return {8'h02, 2'h0, 3'h1};
    if (c < 5'h10) return {8'h04, 2'h0, 3'h4};
    if (c < 5'h18) return {8'h08, 2'h1, 3'h1};
    if (c < 5'h1c) return {8'h10, 2'h2, 3'h1};
    if (c < 5'h1e) return {8'h20, 2'h0, 3'h2};
    if (c == 5'h1e) return {8'h40, 2'h2, 3'h2};
    return {8'h80, 2'h2, 3'h1};
  endfunction : exp_of
  task automatic t_codes;
    logic [12:0] x;
    for (int i = 0; i < 32; i++) begin
      seq.issue(5'(i), SIZE_WORD, LOC_RAM_EVEN, 1'b1, i[0]);
      x = exp_of(5'(i));
      chk("valid", 8'(RESULT_VALID), 8'h01);
      chk("mode", MODE, x[12:5]);
      chk("ext", 8'(EXT_BYTES), 8'(x[4:3]));
      chk("form", 8'(FORM_CYCLES), 8'(x[2:0]));
      chk("len", 8'(TOTAL_LENGTH), 8'h0f + (i[0] ? 8'(x[4:3]) : 8'h0));
      chk("mem", 8'(IS_MEMORY), 8'(i >= 8));
      chk("cyc", TOTAL_CYCLES, 8'h3f + 8'(x[2:0]));
      if (i < 8 || (i >= 16 && i < 24)) chk("wreg", 8'(WORD_REGISTER), 8'(i % 8));
      if (i < 8) chk("breg", 8'(BYTE_REGISTER), 8'(i));
      if (i < 8) chk("lreg", 8'(LONG_REGISTER), 8'(i / 2));
      chk("sofs", 8'(SHORT_OFFSET_FIELD), 8'(i >= 16 && i < 24));
      chk("wofs", 8'(WIDE_OFFSET_FIELD), 8'((i >= 24 && i < 28) || i == 30));
      chk("abs", 8'(ABSOLUTE_16BIT_LOCATION), 8'(i == 31));
      chk("uidx", 8'(USES_INDEX), 8'(i == 28 || i == 29));
      chk("upc", 8'(USES_PC), 8'(i == 30));
    end
    $display("test codes done");
  endtask : t_codes
  task automatic t_corr;
    for (int l = 0; l < 6; l++) begin
      for (int s = 0; s < 3; s++) begin
        seq.issue(5'h08, size_t'(s), loc_t'(l), 1'b1, 1'b0);
        chk("corr", 8'(LOC_CORRECTION), 8'(CTAB[l][s]));
        chk("ccyc", TOTAL_CYCLES, 8'h40 + 8'(CTAB[l][s]));
      end
    end
    seq.issue(5'h03, SIZE_LONG, LOC_EXT_ODD, 1'b1, 1'b0);
    chk("regcorr", 8'(LOC_CORRECTION), 8'h00);
    $display("test corrections done");
  endtask : t_corr
  task automatic t_inc;
    for (int s = 0; s < 3; s++) begin
      seq.issue(5'(12 + s), size_t'(s), LOC_RAM_EVEN, 1'b1, 1'b1);
      chk("step", 8'(POST_INC_STEP), 8'(1 << s));
      chk("ptr", 8'(LOW_WORD_POINTER), 8'(s));
    end
    seq.issue(5'h1d, SIZE_BYTE, LOC_RAM_EVEN, 1'b1, 1'b1);
    chk("idx", 8'(INDEX_REGISTER), 8'h07);
    chk("iptr", 8'(LOW_WORD_POINTER), 8'h01);
    $display("test increments done");
  endtask : t_inc
  task automatic t_hold;
    seq.issue(5'h1f, SIZE_LONG, LOC_BUS8, 1'b1, 1'b1);
    @(posedge CORE_CLK);
    #1;
    chk("idle", 8'(RESULT_VALID), 8'h00);
    chk("hcyc", TOTAL_CYCLES, 8'd70);
    chk("hlen", 8'(TOTAL_LENGTH), 8'd17);
    $display("test hold done");
  endtask : t_hold
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    #20000;
    n_fail++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge CORE_CLK);
    #1;
    RST_N = 1'b1;
    chk("rst", MODE, 8'h01);
    t_codes();
    t_corr();
    t_inc();
    t_hold();
    test_done();
  end
endmodule : effective_address_decode_tb
